// >>> rtl/ntbs_pkg.sv
// Shared constants, register layouts and carriers of the block tiling scheduler
package ntbs_pkg;

   // ==========================================================================
   // Register indices on the plain register port
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_OFM = 4'h1;
   localparam logic [3:0] REG_DEPTH = 4'h2;
   localparam logic [3:0] REG_BLK = 4'h3;
   localparam logic [3:0] REG_KERN = 4'h4;
   localparam logic [3:0] REG_PAD = 4'h5;
   localparam logic [3:0] REG_OPCFG = 4'h6;
   localparam logic [3:0] REG_DEPOFS = 4'h7;
   localparam logic [3:0] REG_STATUS = 4'h8;
   localparam logic [3:0] REG_LIMIT = 4'h9;
   localparam logic [3:0] REG_RATE = 4'ha;
   localparam logic [3:0] REG_OPCNT = 4'hb;

   // ==========================================================================
   // Block size bounds and depth caps
   localparam logic [15:0] BLK_W_MAX = 16'h0040;
   localparam logic [15:0] BLK_H_MAX = 16'h0020;
   localparam logic [15:0] BLK_D_MAX = 16'h0080;
   localparam logic [3:0] DEPTH_SPLIT_MASK = 4'hf;
   localparam logic [19:0] CAP8_32 = 20'h00020;
   localparam logic [19:0] CAP16 = 20'h00010;
   localparam logic [19:0] CAP32B = 20'h00008;
   localparam logic [19:0] GRAN8 = 20'h00008;
   localparam logic [19:0] GRAN16B = 20'h00004;
   localparam logic [19:0] GRAN32B = 20'h00002;

   // Minimum block height, width, depth for builds 32, 64, 128, 256
   localparam logic [7:0] MIN_H [4] = '{8'h01, 8'h01, 8'h01, 8'h02};
   localparam logic [7:0] MIN_W [4] = '{8'h01, 8'h01, 8'h02, 8'h02};
   localparam logic [7:0] MIN_D [4] = '{8'h04, 8'h08, 8'h08, 8'h08};

   // Elementwise ops per cycle in hundredths, by build and operation class
   localparam logic [8:0] RATE [4][8] = '{
      '{9'h032, 9'h032, 9'h021, 9'h019, 9'h011, 9'h032, 9'h032, 9'h021},
      '{9'h064, 9'h064, 9'h043, 9'h032, 9'h021, 9'h064, 9'h064, 9'h043},
      '{9'h0c8, 9'h0c8, 9'h085, 9'h064, 9'h043, 9'h064, 9'h064, 9'h043},
      '{9'h190, 9'h10b, 9'h10b, 9'h0c8, 9'h085, 9'h064, 9'h064, 9'h043}};

   // ==========================================================================
   // Enumerations
   typedef enum logic [2:0] {
      OP_CONV = 3'h0, OP_FC = 3'h1, OP_RSUM = 3'h2,
      OP_DW = 3'h3, OP_POOL = 3'h4, OP_ELEM = 3'h5
   } ntbs_op_t;

   typedef enum logic [1:0] {ACT_8 = 2'h0, ACT_16 = 2'h1, ACT_32 = 2'h2} ntbs_act_t;

   typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_LOAD = 2'h1, ST_RUN = 2'h3} ntbs_fsm_t;

   // ==========================================================================
   // Register layouts
   typedef struct packed {logic [15:0] w; logic [15:0] h;} ntbs_ofm_reg_t;
   typedef struct packed {logic [15:0] ifm_d; logic [15:0] ofm_d;} ntbs_depth_reg_t;
   typedef struct packed {
      logic [10:0] rsv; logic [7:0] d; logic [6:0] w; logic [5:0] h;
   } ntbs_blkcfg_t;
   typedef struct packed {
      logic [7:0] rsv; logic [3:0] split; logic [2:0] dx; logic [2:0] dy;
      logic [2:0] sx; logic [2:0] sy; logic [3:0] kw; logic [3:0] kh;
   } ntbs_kern_reg_t;
   typedef struct packed {
      logic [14:0] rsv; logic up; logic [3:0] r; logic [3:0] l; logic [3:0] b; logic [3:0] t;
   } ntbs_pad_reg_t;
   typedef struct packed {
      logic [21:0] rsv; logic [2:0] eop; logic wo; ntbs_act_t act; logic rsv0; ntbs_op_t op;
   } ntbs_opcfg_t;
   typedef struct packed {logic [7:0] md; logic [15:0] iw; logic [15:0] ih;} ntbs_lim_t;

   // One block operation handed to the datapath
   typedef struct packed {
      logic [15:0] oy; logic [15:0] ox; logic [15:0] oz; logic [15:0] iz;
      logic [5:0] h; logic [6:0] w; logic [7:0] d; logic [7:0] id;
      logic [15:0] n; logic par; logic last_in; logic last;
   } ntbs_blk_t;

   // Round up to a power-of-two granule
   function automatic logic [19:0] align(input logic [19:0] x, input logic [19:0] n);
      return (x + n - 20'h1) & ~(n - 20'h1);
   endfunction

   function automatic logic [19:0] min20(input logic [19:0] a, input logic [19:0] b);
      return (a < b) ? a : b;
   endfunction

endpackage

// >>> rtl/ntbs_limits.sv
// Input block size limits derived from the output block and the operation
`timescale 1ns/1ps
`default_nettype none
module ntbs_limits #(
   parameter int unsigned CFG_SEL = 3
) (
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire ntbs_pkg::ntbs_ofm_reg_t ofm_i,
   input wire ntbs_pkg::ntbs_depth_reg_t dep_i,
   input wire ntbs_pkg::ntbs_blkcfg_t blk_i,
   input wire ntbs_pkg::ntbs_kern_reg_t kern_i,
   input wire ntbs_pkg::ntbs_pad_reg_t pad_i,
   input wire ntbs_pkg::ntbs_opcfg_t opc_i,
   output ntbs_pkg::ntbs_lim_t lim_o
);

   typedef struct packed {ntbs_pkg::ntbs_lim_t lim;} ntbs_lim_st_t;
   ntbs_lim_st_t st_r;
   ntbs_lim_st_t st_nxt;
   logic [19:0] dkh, dkw, h1, h2, w1, w2, d;

   // Input extent for an output extent; halved, rounding up, when upscaling
   function automatic logic [19:0] fm_get(input logic [19:0] o, input logic [19:0] b,
                                          input logic [19:0] s, input logic up);
      logic [19:0] t;
      t = (o - 20'h1) * s + b;
      return up ? ((t + 20'h1) >> 1) : t;
   endfunction

   // Border after padding, never below one row
   function automatic logic [19:0] border(input logic [19:0] k, input logic [19:0] p);
      return (k > p) ? k - p : 20'h1;
   endfunction

   // ==========================================================================
   // Limit arithmetic
   always_comb begin
      st_nxt = st_r;
      dkh = (20'(kern_i.kh) - 20'h1) * 20'(kern_i.dy) + 20'h1; // RQ16
      dkw = (20'(kern_i.kw) - 20'h1) * 20'(kern_i.dx) + 20'h1; // RQ16
      h1 = fm_get(20'(blk_i.h), ntbs_pkg::min20(20'(kern_i.split), dkh), 20'(kern_i.sy), pad_i.up);
      h2 = fm_get(20'(ofm_i.h), border(dkh, 20'(pad_i.t) + 20'(pad_i.b)), 20'(kern_i.sy), pad_i.up);
      w1 = fm_get(20'(blk_i.w), ntbs_pkg::min20(20'(kern_i.split), dkw), 20'(kern_i.sx), pad_i.up);
      w2 = fm_get(20'(ofm_i.w), border(dkw, 20'(pad_i.l) + 20'(pad_i.r)), 20'(kern_i.sx), pad_i.up);
      st_nxt.lim.ih = 16'(ntbs_pkg::align(ntbs_pkg::min20(h1, h2), 20'(ntbs_pkg::MIN_H[CFG_SEL]))); // RQ9
      st_nxt.lim.iw = 16'(ntbs_pkg::align(ntbs_pkg::min20(w1, w2), 20'(ntbs_pkg::MIN_W[CFG_SEL]))); // RQ10
      d = 20'(dep_i.ifm_d);
      case (opc_i.op)
         ntbs_pkg::OP_DW, ntbs_pkg::OP_POOL, ntbs_pkg::OP_ELEM: begin
            st_nxt.lim.md = blk_i.d; // RQ11
         end
         default: begin
            case (opc_i.act)
               ntbs_pkg::ACT_8: begin
                  if (!opc_i.wo) begin
                     st_nxt.lim.md = 8'(ntbs_pkg::align(ntbs_pkg::min20(ntbs_pkg::CAP8_32, d),
                                                        ntbs_pkg::GRAN8)); // RQ12
                  end else begin
                     st_nxt.lim.md = 8'(ntbs_pkg::align(ntbs_pkg::min20(ntbs_pkg::CAP16, d),
                                                        ntbs_pkg::GRAN8)); // RQ13
                  end
               end
               ntbs_pkg::ACT_32: begin
                  st_nxt.lim.md = 8'(ntbs_pkg::align(ntbs_pkg::min20(ntbs_pkg::CAP32B, d),
                                                     ntbs_pkg::GRAN32B)); // RQ15
               end
               default: begin
                  st_nxt.lim.md = 8'(ntbs_pkg::align(ntbs_pkg::min20(ntbs_pkg::CAP16, d),
                                                     ntbs_pkg::GRAN16B)); // RQ14
               end
            endcase
         end
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign lim_o = st_r.lim;

endmodule // ntbs_limits
`default_nettype wire

// >>> rtl/ntbs_dep_gate.sv
// Counts committed output block writes of the prior operation and gates reads
`timescale 1ns/1ps
`default_nettype none
module ntbs_dep_gate (
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic op_start_i,
   input wire logic [15:0] prev_total_i,
   input wire logic [15:0] k_i,
   input wire logic [15:0] n_i,
   input wire logic wr_done_i,
   input wire logic wr_par_i,
   output logic par_o,
   output logic ok_o
);

   typedef struct packed {
      logic [15:0] done0;
      logic [15:0] done1;
      logic [15:0] prev_total;
      logic seen;
      logic prev_vld;
      logic par;
   } ntbs_dep_st_t;
   ntbs_dep_st_t st_r;
   ntbs_dep_st_t st_nxt;
   logic [15:0] slack, need, prev_done;

   // ==========================================================================
   // Write completion counting, one counter per operation parity
   always_comb begin
      st_nxt = st_r;
      if (wr_done_i && !wr_par_i) begin
         st_nxt.done0 = st_r.done0 + 16'h0001; // RQ23
      end
      if (wr_done_i && wr_par_i) begin
         st_nxt.done1 = st_r.done1 + 16'h0001; // RQ23
      end
      if (op_start_i) begin
         st_nxt.par = !st_r.par;
         st_nxt.seen = 1'b1;
         st_nxt.prev_vld = st_r.seen;
         st_nxt.prev_total = prev_total_i;
         if (st_r.par) begin
            st_nxt.done0 = '0;
         end else begin
            st_nxt.done1 = '0;
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Read n may start once all but max(k-n,0) prior writes have landed
   always_comb begin
      slack = (k_i > n_i) ? k_i - n_i : '0; // RQ20
      need = (st_r.prev_total > slack) ? st_r.prev_total - slack : '0; // RQ20
      prev_done = st_r.par ? st_r.done0 : st_r.done1;
      ok_o = !st_r.prev_vld || (prev_done >= need); // RQ17
   end

   assign par_o = st_r.par;

endmodule // ntbs_dep_gate
`default_nettype wire

// >>> rtl/ntbs_top.sv
// Block tiling and dependency scheduler: registers, checks, block sequencing
//
// Contract
// RQ1: Each stripe runs block by block; edge blocks are trimmed to what remains.
// RQ2: Output blocks step depth first, then horizontally, then vertically.
// RQ3: Producer sets block width 1..64, a multiple of minimum width.
// RQ4: Producer sets block height 1..32, a multiple of minimum height.
// RQ5: Producer sets block depth 1..128, a multiple of minimum depth.
// RQ6: Block depth not a multiple of 16 needs output depth within one block.
// RQ7: Minimum block sizes follow the build: 32,64,128,256 wide tables.
// RQ8: Producer keeps input and output block allocations within the shared buffer.
// RQ9: Input block height limit from block rows, padded output rows, upscale, alignment.
// RQ10: Input block width limit likewise from stride, clipped dilated kernel, padding.
// RQ11: Depthwise, pooling and elementwise read input depth equal to block depth.
// RQ12: Conv-like 8-bit, order zero: input depth capped 32, aligned to 8.
// RQ13: Conv-like 8-bit, order one: input depth capped 16, aligned to 8.
// RQ14: Conv-like 16-bit: input depth capped 16, aligned to 4.
// RQ15: Reduce-sum 32-bit: input depth capped 8, aligned to 2.
// RQ16: Align rounds up to a multiple; dilated kernel is (size-1)*dilation+1.
// RQ17: Dependency offset comes from commands; reads wait for the writes they need.
// RQ18: Position-wise operations read the input block at the output block position.
// RQ19: Convolution steps input depth blocks per output block, each its own block op.
// RQ20: Read n waits for all prior writes except max(k-n,0).
// RQ21: 8-bit elementwise rates per build, 0.5 up to 4 operations per cycle.
// RQ22: Int32 leading-zero and shift rates per build as tabulated.
// RQ23: Committed prior writes are counted and dependent reads stall on the count.
`timescale 1ns/1ps
`default_nettype none
module ntbs_top #(
   parameter int unsigned CFG_SEL = 3
) (
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic [3:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   output logic blk_valid_o,
   input wire logic blk_ready_i,
   output ntbs_pkg::ntbs_blk_t blk_o,
   input wire logic wr_done_i,
   input wire logic wr_par_i,
   output logic busy_o,
   output logic cfg_err_o
);

   typedef struct packed {
      ntbs_pkg::ntbs_fsm_t st;
      ntbs_pkg::ntbs_ofm_reg_t ofm;
      ntbs_pkg::ntbs_depth_reg_t dep;
      ntbs_pkg::ntbs_blkcfg_t blk;
      ntbs_pkg::ntbs_kern_reg_t kern;
      ntbs_pkg::ntbs_pad_reg_t pad;
      ntbs_pkg::ntbs_opcfg_t opc;
      logic [15:0] k;
      logic [15:0] oy;
      logic [15:0] ox;
      logic [15:0] oz;
      logic [15:0] iz;
      logic [15:0] n;
      logic [15:0] otot;
      logic [15:0] ops;
      logic [31:0] rdata;
      ntbs_pkg::ntbs_blk_t bo;
   } ntbs_top_st_t;

   ntbs_top_st_t st_r;
   ntbs_top_st_t st_nxt;
   ntbs_pkg::ntbs_lim_t lim;
   logic dep_ok;
   logic par;
   logic op_start;
   logic conv_like;
   logic err_w, err_h, err_d, err_dd;
   logic fire;
   logic [15:0] oy_n, ox_n, oz_n, iz_n;
   logic l_iz, l_z, l_x, l_y;

   // Smaller of a configured block extent and what is left of the map
   function automatic logic [15:0] remain(input logic [15:0] blk, input logic [15:0] dim,
                                          input logic [15:0] pos);
      return (blk < dim - pos) ? blk : dim - pos;
   endfunction

   // Block size legal: within range and a multiple of the build minimum
   function automatic logic size_bad(input logic [15:0] v, input logic [15:0] vmax,
                                     input logic [7:0] vmin);
      return (v == '0) || (v > vmax) || ((v & (16'(vmin) - 16'h0001)) != '0);
   endfunction

   // ==========================================================================
   // Submodules
   ntbs_limits #(
      .CFG_SEL(CFG_SEL)
   ) u_limits (
      .ref_clk_i(ref_clk_i),
      .srst_i(srst_i),
      .ofm_i(st_r.ofm),
      .dep_i(st_r.dep),
      .blk_i(st_r.blk),
      .kern_i(st_r.kern),
      .pad_i(st_r.pad),
      .opc_i(st_r.opc),
      .lim_o(lim)
   );

   ntbs_dep_gate u_dep (
      .ref_clk_i(ref_clk_i),
      .srst_i(srst_i),
      .op_start_i(op_start),
      .prev_total_i(st_r.otot),
      .k_i(st_r.k),
      .n_i(st_r.n),
      .wr_done_i(wr_done_i),
      .wr_par_i(wr_par_i),
      .par_o(par),
      .ok_o(dep_ok)
   );

   // ==========================================================================
   // Command checks against the build minimums
   always_comb begin
      err_w = size_bad(16'(st_r.blk.w), ntbs_pkg::BLK_W_MAX, ntbs_pkg::MIN_W[CFG_SEL]); // RQ3 RQ7
      err_h = size_bad(16'(st_r.blk.h), ntbs_pkg::BLK_H_MAX, ntbs_pkg::MIN_H[CFG_SEL]); // RQ4 RQ7
      err_d = size_bad(16'(st_r.blk.d), ntbs_pkg::BLK_D_MAX, ntbs_pkg::MIN_D[CFG_SEL]); // RQ5 RQ7
      err_dd = ((st_r.blk.d[3:0] & ntbs_pkg::DEPTH_SPLIT_MASK) != 4'h0)
               && (st_r.dep.ofm_d > 16'(st_r.blk.d)); // RQ6
      cfg_err_o = err_w || err_h || err_d || err_dd;
   end

   assign conv_like = (st_r.opc.op == ntbs_pkg::OP_CONV) || (st_r.opc.op == ntbs_pkg::OP_FC)
                      || (st_r.opc.op == ntbs_pkg::OP_RSUM);

   // ==========================================================================
   // Block stepping: input depth, then output depth, horizontal, vertical
   always_comb begin
      l_iz = !conv_like || (st_r.iz + 16'(lim.md) >= st_r.dep.ifm_d); // RQ19
      l_z = st_r.oz + 16'(st_r.blk.d) >= st_r.dep.ofm_d; // RQ2
      l_x = st_r.ox + 16'(st_r.blk.w) >= st_r.ofm.w; // RQ2
      l_y = st_r.oy + 16'(st_r.blk.h) >= st_r.ofm.h; // RQ2
      iz_n = st_r.iz;
      oz_n = st_r.oz;
      ox_n = st_r.ox;
      oy_n = st_r.oy;
      if (!l_iz) begin
         iz_n = st_r.iz + 16'(lim.md); // RQ19
      end else begin
         iz_n = '0;
         if (!l_z) begin
            oz_n = st_r.oz + 16'(st_r.blk.d);
         end else begin
            oz_n = '0;
            if (!l_x) begin
               ox_n = st_r.ox + 16'(st_r.blk.w);
            end else begin
               ox_n = '0;
               if (!l_y) begin
                  oy_n = st_r.oy + 16'(st_r.blk.h);
               end else begin
                  oy_n = '0;
               end
            end
         end
      end
   end

   assign op_start = reg_wr_i && (reg_addr_i == ntbs_pkg::REG_CTRL) && reg_wdata_i[0]
                     && (st_r.st == ntbs_pkg::ST_IDLE) && !cfg_err_o;
   assign fire = blk_valid_o && blk_ready_i;

   // ==========================================================================
   // State update
   always_comb begin
      st_nxt = st_r;
      if (reg_wr_i && (st_r.st == ntbs_pkg::ST_IDLE)) begin
         case (reg_addr_i)
            ntbs_pkg::REG_OFM: begin
               st_nxt.ofm = reg_wdata_i;
            end
            ntbs_pkg::REG_DEPTH: begin
               st_nxt.dep = reg_wdata_i;
            end
            ntbs_pkg::REG_BLK: begin
               st_nxt.blk = reg_wdata_i;
            end
            ntbs_pkg::REG_KERN: begin
               st_nxt.kern = reg_wdata_i;
            end
            ntbs_pkg::REG_PAD: begin
               st_nxt.pad = reg_wdata_i;
            end
            ntbs_pkg::REG_OPCFG: begin
               st_nxt.opc = reg_wdata_i;
            end
            ntbs_pkg::REG_DEPOFS: begin
               st_nxt.k = reg_wdata_i[15:0]; // RQ17
            end
            default: begin
               st_nxt.k = st_r.k;
            end
         endcase
      end
      case (st_r.st)
         ntbs_pkg::ST_IDLE: begin
            if (op_start) begin
               st_nxt.st = ntbs_pkg::ST_LOAD;
               st_nxt.oy = '0;
               st_nxt.ox = '0;
               st_nxt.oz = '0;
               st_nxt.iz = '0;
               st_nxt.n = '0;
               st_nxt.otot = '0;
            end
         end
         ntbs_pkg::ST_LOAD: begin
            st_nxt.st = ntbs_pkg::ST_RUN;
         end
         ntbs_pkg::ST_RUN: begin
            if (fire) begin
               st_nxt.n = st_r.n + 16'h0001; // RQ19
               st_nxt.iz = iz_n;
               st_nxt.oz = oz_n;
               st_nxt.ox = ox_n;
               st_nxt.oy = oy_n;
               if (l_iz) begin
                  st_nxt.otot = st_r.otot + 16'h0001; // RQ23
               end
               if (l_iz && l_z && l_x && l_y) begin
                  st_nxt.st = ntbs_pkg::ST_IDLE;
                  st_nxt.ops = st_r.ops + 16'h0001;
               end
            end
         end
         default: begin
            st_nxt.st = ntbs_pkg::ST_IDLE;
         end
      endcase
      // Descriptor of the block op now standing at the counters
      st_nxt.bo.oy = st_nxt.oy;
      st_nxt.bo.ox = st_nxt.ox;
      st_nxt.bo.oz = st_nxt.oz;
      st_nxt.bo.iz = conv_like ? st_nxt.iz : st_nxt.oz; // RQ18
      st_nxt.bo.h = 6'(remain(16'(st_r.blk.h), st_r.ofm.h, st_nxt.oy)); // RQ1
      st_nxt.bo.w = 7'(remain(16'(st_r.blk.w), st_r.ofm.w, st_nxt.ox)); // RQ1
      st_nxt.bo.d = 8'(remain(16'(st_r.blk.d), st_r.dep.ofm_d, st_nxt.oz)); // RQ1
      st_nxt.bo.id = conv_like ? 8'(remain(16'(lim.md), st_r.dep.ifm_d, st_nxt.iz))
                               : st_nxt.bo.d; // RQ11
      st_nxt.bo.n = st_nxt.n;
      st_nxt.bo.par = par;
      st_nxt.bo.last_in = !conv_like || (st_nxt.iz + 16'(lim.md) >= st_r.dep.ifm_d);
      st_nxt.bo.last = (st_nxt.oy + 16'(st_r.blk.h) >= st_r.ofm.h)
                       && (st_nxt.ox + 16'(st_r.blk.w) >= st_r.ofm.w)
                       && (st_nxt.oz + 16'(st_r.blk.d) >= st_r.dep.ofm_d)
                       && st_nxt.bo.last_in;
      // Register read port
      st_nxt.rdata = '0;
      if (reg_rd_i) begin
         case (reg_addr_i)
            ntbs_pkg::REG_OFM: begin
               st_nxt.rdata = st_r.ofm;
            end
            ntbs_pkg::REG_DEPTH: begin
               st_nxt.rdata = st_r.dep;
            end
            ntbs_pkg::REG_BLK: begin
               st_nxt.rdata = st_r.blk;
            end
            ntbs_pkg::REG_KERN: begin
               st_nxt.rdata = st_r.kern;
            end
            ntbs_pkg::REG_PAD: begin
               st_nxt.rdata = st_r.pad;
            end
            ntbs_pkg::REG_OPCFG: begin
               st_nxt.rdata = st_r.opc;
            end
            ntbs_pkg::REG_DEPOFS: begin
               st_nxt.rdata = {16'h0000, st_r.k};
            end
            ntbs_pkg::REG_STATUS: begin
               st_nxt.rdata = {st_r.n, 8'h00, par, dep_ok, err_dd, err_d, err_h, err_w,
                               (st_r.st != ntbs_pkg::ST_IDLE), cfg_err_o};
            end
            ntbs_pkg::REG_LIMIT: begin
               st_nxt.rdata = lim[31:0];
            end
            ntbs_pkg::REG_RATE: begin
               st_nxt.rdata = {lim.md, 15'h0000, ntbs_pkg::RATE[CFG_SEL][st_r.opc.eop]}; // RQ21 RQ22
            end
            ntbs_pkg::REG_OPCNT: begin
               st_nxt.rdata = {st_r.otot, st_r.ops};
            end
            default: begin
               st_nxt.rdata = '0;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ==========================================================================
   // Outputs
   assign blk_valid_o = (st_r.st == ntbs_pkg::ST_RUN) && dep_ok; // RQ20 RQ23
   assign blk_o = st_r.bo;
   assign busy_o = (st_r.st != ntbs_pkg::ST_IDLE);
   assign reg_rdata_o = st_r.rdata;

endmodule // ntbs_top
`default_nettype wire

// >>> test/ntbs_chk.sv
// Port checker of the block tiling scheduler
`timescale 1ns/1ps
`default_nettype none
module ntbs_chk (
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic [3:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic blk_valid_o,
   input wire logic blk_ready_i,
   input wire ntbs_pkg::ntbs_blk_t blk_o,
   input wire logic busy_o,
   input wire logic cfg_err_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (srst_i);
   sequence s_go;
      reg_wr_i && reg_addr_i == ntbs_pkg::REG_CTRL && reg_wdata_i[0] && !busy_o;
   endsequence
   sequence s_take;
      blk_valid_o && blk_ready_i;
   endsequence
   a_valid_busy: assert property (blk_valid_o |-> busy_o)
      else $error("valid outside op");
   a_desc_hold: assert property (blk_valid_o && !blk_ready_i |=> $stable(blk_o))
      else $error("descriptor moved");
   a_index_step: assert property (s_take ##0 !blk_o.last |=> blk_o.n == $past(blk_o.n) + 16'h1)
      else $error("index skipped");
   a_last_ends: assert property (s_take ##0 blk_o.last |=> !busy_o && !blk_valid_o)
      else $error("op not ended");
   a_size_cap: assert property (blk_valid_o |-> blk_o.w inside {[7'h1:7'h40]} && blk_o.h inside {[6'h1:6'h20]})
      else $error("block size");
   a_start_busy: assert property (s_go ##0 !cfg_err_o |=> busy_o [*2])
      else $error("start lost");
   a_err_block: assert property (s_go ##0 cfg_err_o |=> !busy_o)
      else $error("bad config started");
   a_first_pos: assert property (s_go ##0 !cfg_err_o |=> ##1 blk_o.n == 16'h0 && blk_o.ox == 16'h0)
      else $error("first block");
endmodule // ntbs_chk
`default_nettype wire

// >>> test/ntbs_mem_model.sv
// Far side: takes block ops and commits their output writes late
`timescale 1ns/1ps
`default_nettype none
module ntbs_mem_model (
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic blk_valid_i,
   input wire ntbs_pkg::ntbs_blk_t blk_i,
   output logic blk_ready_o,
   output logic wr_done_o,
   output logic wr_par_o
);
   logic pend_q[$];
   logic [2:0] tick_r = 3'h0;
   initial {blk_ready_o, wr_done_o, wr_par_o} = 3'h0;
   always @(posedge ref_clk_i) begin
      tick_r <= tick_r + 3'h1;
      wr_done_o <= 1'b0;
      blk_ready_o <= !srst_i && tick_r[1:0] != 2'h3; // Stall one cycle in four
      if (srst_i) pend_q.delete();
      else begin
         if (blk_valid_i && blk_ready_o && blk_i.last_in) pend_q.push_back(blk_i.par);
         if (tick_r == 3'h0 && pend_q.size() > 0) begin
            wr_done_o <= 1'b1;
            wr_par_o <= pend_q.pop_front();
         end else wr_par_o <= ~wr_par_o;
      end
   end
endmodule // ntbs_mem_model
`default_nettype wire

// >>> test/tb_top.sv
// Self-checking bench of the block tiling scheduler
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic ref_clk_i = 1'b0, srst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
   logic [3:0] reg_addr_i = 4'h0;
   logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o;
   logic blk_valid_o, blk_ready_i, wr_done_i, wr_par_i, busy_o, cfg_err_o;
   ntbs_pkg::ntbs_blk_t blk_o, g, log_q[8];
   int fail_count = 0, checks = 0, nlog = 0, commits = 0, j, seen[8];
   logic [31:0] cfgs[5] = '{32'h0, 32'hc0, 32'h310, 32'h3a2, 32'h103};
   logic [31:0] deps[5] = '{32'h140018, 32'h140018, 32'h70018, 32'h50018, 32'h140018};
   logic [31:0] exps[5] = '{32'h18000190, 32'h1000010b, 32'h08000064, 32'h06000043, 32'h1000010b};
   initial forever #2 ref_clk_i = ~ref_clk_i;
   ntbs_top #(.CFG_SEL(3)) i_ntbs_top (.ref_clk_i, .srst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
      .reg_rdata_o, .blk_valid_o, .blk_ready_i, .blk_o, .wr_done_i, .wr_par_i, .busy_o, .cfg_err_o);
   ntbs_mem_model i_ntbs_mem_model (.ref_clk_i, .srst_i, .blk_valid_i(blk_valid_o), .blk_i(blk_o),
      .blk_ready_o(blk_ready_i), .wr_done_o(wr_done_i), .wr_par_o(wr_par_i));
   always @(posedge ref_clk_i) begin
      if (blk_valid_o && blk_ready_i && nlog < 8) begin
         log_q[nlog] = blk_o;
         seen[nlog] = commits;
         nlog++;
      end
      if (wr_done_i) commits++;
   end
   task automatic chk(input string nm, input logic [127:0] x, input logic [127:0] y);
      checks++;
      if (x !== y) begin
         fail_count++;
         $display("BAD %s exp %h got %h", nm, x, y);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      {reg_addr_i, reg_wdata_i, reg_wr_i, reg_rd_i} <= {a, d, 2'b10};
      @(posedge ref_clk_i);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] x, input logic [31:0] m);
      {reg_addr_i, reg_wr_i, reg_rd_i} <= {a, 2'b01};
      @(posedge ref_clk_i);
      reg_rd_i <= 1'b0;
      #1 chk("rdata", x, reg_rdata_o & m);
      @(posedge ref_clk_i);
   endtask
   task automatic run_op();
      wr(4'h0, 32'h1);
      {reg_wr_i, reg_rd_i} <= 2'b00;
      repeat (2) @(posedge ref_clk_i);
      for (int i = 0; i < 400 && busy_o === 1'b1; i++) @(posedge ref_clk_i);
      chk("busy", 0, busy_o);
   endtask
   task automatic complete_run();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      #20000 fail_count++;
      complete_run();
   end
   initial begin
      repeat (3) @(posedge ref_clk_i);
      srst_i <= 1'b0;
      @(posedge ref_clk_i);
      rd(4'h8, 32'h1, 32'h3);
      wr(4'h1, 32'h30002);
      wr(4'h4, 32'h824a33);
      wr(4'h5, 32'h0);
      wr(4'h7, 32'h2);
      wr(4'h3, 32'h200c2);
      wr(4'h0, 32'h1);
      rd(4'h8, 32'h5, 32'h7);
      wr(4'h3, 32'h20082);
      for (int i = 0; i < 5; i++) begin
         wr(4'h6, cfgs[i]);
         repeat (2) wr(4'h2, deps[i]); // Extra cycle lets the registered limits settle
         rd(4'ha, exps[i], 32'hff0001ff);
      end
      wr(4'h2, 32'h180018);
      wr(4'h6, 32'h5);
      rd(4'h9, 32'h40006, '1);
      run_op();
      run_op();
      wr(4'h3, 32'h10082);
      rd(4'h8, 32'h21, 32'h3f);
      for (int i = 0; i < 8; i++) begin
         j = i % 4;
         g = log_q[i];
         g.par = 1'b0;
         chk("block", {16'h0, 16'(j / 2 * 2), 16'(j % 2 * 16), 16'(j % 2 * 16), 6'h2, 7'(2 - j / 2),
            8'(16 - j % 2 * 8), 8'(16 - j % 2 * 8), 16'(j), 2'b01, j == 3}, g);
         if (i > 3) chk("commits", 1, seen[i] >= (i < 6 ? i - 2 : 4));
      end
      complete_run();
   end
endmodule // tb_top
bind ntbs_top ntbs_chk i_ntbs_chk (.ref_clk_i, .srst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .blk_valid_o,
   .blk_ready_i, .blk_o, .busy_o, .cfg_err_o);
`default_nettype wire
